// file: shared/port_mux_pkg.sv
// Purpose: Constants and types shared by the port and pin-function mux.
// Assumes: Pin index is port number times eight plus bit number.
// Notes: Ports 0 to 9 map onto an 80-bit flat pin vector.
package port_mux_pkg;
   // ==========================================================
   // Pin layout
   localparam int NUM_PORTS = 10;
   localparam int NUM_PINS = 80;
   // Pins that exist on each port (4, 3, 8, 8, 8, 8, 4, 8, 8, 5 bits)
   localparam logic [79:0] PIN_EXISTS = 80'h1f_ff_ff_0f_ff_ff_ff_ff_07_0f;
   // Pins with an output driver; port 2 bit 0 and ports 7, 8 are input only
   localparam logic [79:0] PIN_BIDIR = 80'h1f_00_00_0f_ff_ff_ff_fe_07_0f;
   // ==========================================================
   // Pin positions of shared functions
   localparam int PIN_NMI = 16;
   localparam int PIN_P2_BASE = 16;
   localparam int PIN_P3_BASE = 24;
   localparam int PIN_P4_BASE = 32;
   localparam int PIN_P5_BASE = 40;
   localparam int PIN_P6_BASE = 48;
   localparam int PIN_P7_BASE = 56;
   localparam int PIN_P9_BASE = 72;
   localparam int PIN_READ_STROBE = 72;
   localparam int PIN_LOW_WR = 73;
   localparam int PIN_HIGH_WR = 74;
   localparam int PIN_ADDR_LATCH = 75;
   localparam int PIN_WAIT = 76;
   // Pull-up groups: ports 0, 4, 5, 6, 9
   localparam int PU_GROUPS = 5;
   // ==========================================================
   // Reset values
   localparam logic DIR_RESET = 1'b1;
   localparam logic LATCH_RESET = 1'b0;
   localparam logic [7:0] FUNC_RESET = 8'h00;
   // Register kinds on the write port
   typedef enum logic [1:0] {
      KIND_LATCH,
      KIND_DIR,
      KIND_FUNC,
      KIND_NONE
   } reg_kind_t;
endpackage : port_mux_pkg

// file: rtl/pin_cell.sv
// Purpose: One port pin: latch, direction, alternate override, pull-up, read.
// Assumes: pin_s is already synchronised to sys_clk.
// Notes: All outputs are registered.
`timescale 1ns/100ps
`default_nettype none
module pin_cell
   import port_mux_pkg::*;
#(
   parameter bit EXISTS = 1'b1,
   parameter bit BIDIR = 1'b1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register writes
   input wire logic wr_latch,
   input wire logic wr_dir,
   input wire logic wdata,
   // Pin and alternate function
   input wire logic pin_s,
   input wire logic alt_sel,
   input wire logic alt_o,
   input wire logic alt_oe,
   input wire logic pull_grp,
   // Results
   output logic pin_o,
   output logic pin_oe,
   output logic pin_pu,
   output logic rd
);

   logic latch_q, latch_d;
   logic dir_q, dir_d;
   logic pin_o_q, pin_o_d, pin_oe_q, pin_oe_d, pin_pu_q, pin_pu_d, rd_q, rd_d;

   always_comb begin
      latch_d = wr_latch ? wdata : latch_q;
      // Input-only pins keep their direction bit at one
      dir_d = (wr_dir && BIDIR) ? wdata : dir_q;                // see R19
      // Alternate output takes the driver from the latch
      pin_o_d = EXISTS && (alt_sel ? alt_o : latch_q);           // see R22
      pin_oe_d = EXISTS && BIDIR && (alt_sel ? alt_oe : !dir_q); // see R1
      // Pull-up only on pins in input mode
      pin_pu_d = EXISTS && pull_grp && dir_q && !(alt_sel && alt_oe); // see R2
      rd_d = EXISTS && (dir_q ? pin_s : latch_q);                // see R21
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= LATCH_RESET;
         dir_q <= DIR_RESET;                                     // see R18
         pin_o_q <= 1'b0;
         pin_oe_q <= 1'b0;
         pin_pu_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         latch_q <= latch_d;
         dir_q <= dir_d;
         pin_o_q <= pin_o_d;
         pin_oe_q <= pin_oe_d;
         pin_pu_q <= pin_pu_d;
         rd_q <= rd_d;
      end
   end

   assign pin_o = pin_o_q;
   assign pin_oe = pin_oe_q;
   assign pin_pu = pin_pu_q;
   assign rd = rd_q;
endmodule : pin_cell
`default_nettype wire

// file: rtl/port_pin_function_mux.sv
// Purpose: Port direction, pull-up and pin-function multiplexing for 64 I/O lines.
// Assumes: Peripherals and bus controller run on sys_clk; pins are asynchronous.
// Notes: system_clock_out toggles every sys_clk cycle outside IDLE and STOP, so sys_clk is twice fxx.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: Ports 0,1,2(1-7),3,4,5,6,9 have per-bit input/output direction.
// R2: One pull-up setting per port 0,4,5,6,9 for its input-mode pins.
// R3: Port 2 bit 0 is input only and carries the non-maskable request.
// R4: Ports 7 and 8 are input-only and carry the analog channels.
// R5: Port 2 bits 1-7 are interrupt inputs; 0-3 are capture triggers.
// R6: Interrupt input 4 also starts an A/D conversion.
// R7: Timer 0 outputs on port 2 bits 1-4, timer 1 on port 3 bits 0-1.
// R8: Port 3 bits 2-4 carry UART 0 or serial channel 1.
// R9: Port 3 bits 5-7 carry UART 2 or serial channel 2; shift clocks bidirectional.
// R10: External bus: port 4 low address/data; port 5 high data or address.
// R11: Port 6 outputs upper address bits, as many as the space needs.
// R12: Port 9 bit 0 outputs the read strobe when the bus is active.
// R13: Low write strobe alone for 8-bit bus; high strobe added for 16-bit.
// R14: Port 9 bit 3 outputs the address latch strobe.
// R15: Outside logic drives the wait pin and the bus width pin.
// R16: Mode input selects standby-disabled mode; test mode input held low.
// R17: Clock out is low in IDLE and STOP, toggling otherwise.
// R18: All direction bits reset to one, pins in input mode.
// R19: Port 2 bit 0 direction bit is forced to one.
// R20: Ports 2, 3, 9 have function select registers resetting to zero.
// R21: Port read gives pin level for inputs, latch for outputs.
// R22: Alternate output function overrides the port output latch.
module port_pin_function_mux
   import port_mux_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register write port
   input wire logic reg_wr,
   input wire logic [3:0] reg_port,
   input wire reg_kind_t reg_kind,
   input wire logic [7:0] reg_wdata,
   input wire logic [PU_GROUPS-1:0] pullup_en,
   // Pins
   input wire logic [NUM_PINS-1:0] pin_i,
   output logic [NUM_PINS-1:0] pin_o,
   output logic [NUM_PINS-1:0] pin_oe,
   output logic [NUM_PINS-1:0] pin_pu,
   output logic [NUM_PINS-1:0] port_rd,
   // Interrupt, capture and converter inputs
   output logic nmi_req,
   output logic [6:0] ext_irq_inputs,
   output logic [3:0] capture_trig,
   output logic adc_start_trig,
   output logic [15:0] analog_channel_inputs,
   // Timers
   input wire logic [3:0] timer0_outputs,
   input wire logic timer1_output_a,
   input wire logic timer1_output_b,
   // Serial units
   input wire logic sio1_mode,
   input wire logic sio2_mode,
   input wire logic uart0_transmit_out,
   input wire logic uart2_transmit_out,
   input wire logic sio1_serial_out,
   input wire logic sio2_serial_out,
   input wire logic sio1_clk_o,
   input wire logic sio1_clk_oe,
   input wire logic sio2_clk_o,
   input wire logic sio2_clk_oe,
   output logic uart0_receive_in,
   output logic uart0_baud_clock_in,
   output logic uart2_receive_in,
   output logic uart2_baud_clock_in,
   output logic sio1_serial_in,
   output logic sio1_shift_clock,
   output logic sio2_serial_in,
   output logic sio2_shift_clock,
   // External bus
   input wire logic ext_mem_en,
   input wire logic [15:0] bus_ad_o,
   input wire logic bus_ad_oe,
   input wire logic [3:0] upper_address_bits,
   input wire logic [3:0] upper_addr_used,
   input wire logic read_strobe,
   input wire logic low_byte_write_strobe,
   input wire logic high_byte_write_strobe,
   input wire logic address_latch_strobe,
   output logic [15:0] muxed_addr_data_bus,
   output logic bus_wait_in,
   // Mode and clock pins
   input wire logic bus_width_select,
   input wire logic standby_disable_select,
   input wire logic test_mode_pin,
   input wire logic idle_mode,
   input wire logic stop_mode,
   output logic bus_width_16,
   output logic standby_disabled,
   output logic system_clock_out
);
   // ==========================================================
   // Pin synchronisers
   logic [NUM_PINS-1:0] pin_m_q, pin_s_q;
   logic [2:0] mode_m_q, mode_s_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_m_q <= '0;
         pin_s_q <= '0;
         mode_m_q <= '0;
         mode_s_q <= '0;
      end else begin
         pin_m_q <= pin_i;
         pin_s_q <= pin_m_q;
         mode_m_q <= {test_mode_pin, standby_disable_select, bus_width_select};
         mode_s_q <= mode_m_q;
      end
   end

   assign nmi_req = pin_s_q[PIN_NMI];                                    // see R3
   assign ext_irq_inputs = pin_s_q[PIN_P2_BASE+7:PIN_P2_BASE+1];         // see R5
   assign capture_trig = pin_s_q[PIN_P2_BASE+4:PIN_P2_BASE+1];           // see R5
   assign adc_start_trig = pin_s_q[PIN_P2_BASE+5];                       // see R6
   assign analog_channel_inputs = pin_s_q[PIN_P7_BASE+15:PIN_P7_BASE];   // see R4
   assign uart0_receive_in = pin_s_q[PIN_P3_BASE+2];                     // see R8
   assign sio1_serial_in = pin_s_q[PIN_P3_BASE+2];
   assign uart0_baud_clock_in = pin_s_q[PIN_P3_BASE+4];
   assign sio1_shift_clock = pin_s_q[PIN_P3_BASE+4];
   assign uart2_receive_in = pin_s_q[PIN_P3_BASE+5];                     // see R9
   assign sio2_serial_in = pin_s_q[PIN_P3_BASE+5];
   assign uart2_baud_clock_in = pin_s_q[PIN_P3_BASE+7];
   assign sio2_shift_clock = pin_s_q[PIN_P3_BASE+7];
   assign muxed_addr_data_bus = pin_s_q[PIN_P5_BASE+7:PIN_P4_BASE];      // see R10
   assign bus_wait_in = pin_s_q[PIN_WAIT];                               // see R15
   assign bus_width_16 = mode_s_q[0];

   // ==========================================================
   // Function select registers of ports 2, 3, 9
   logic [7:0] port2_function_select_q, port2_function_select_d;
   logic [7:0] port3_function_select_q, port3_function_select_d;
   logic [7:0] port9_function_select_q, port9_function_select_d;
   always_comb begin
      port2_function_select_d = port2_function_select_q;
      port3_function_select_d = port3_function_select_q;
      port9_function_select_d = port9_function_select_q;
      if (reg_wr && reg_kind == KIND_FUNC) begin                         // see R20
         case (reg_port)
            4'h2: port2_function_select_d = reg_wdata;
            4'h3: port3_function_select_d = reg_wdata;
            4'h9: port9_function_select_d = reg_wdata;
            default: ;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         port2_function_select_q <= FUNC_RESET;
         port3_function_select_q <= FUNC_RESET;
         port9_function_select_q <= FUNC_RESET;
      end else begin
         port2_function_select_q <= port2_function_select_d;
         port3_function_select_q <= port3_function_select_d;
         port9_function_select_q <= port9_function_select_d;
      end
   end

   // ==========================================================
   // Alternate function routing
   logic [NUM_PINS-1:0] alt_sel, alt_o, alt_oe;
   always_comb begin
      alt_sel = '0;
      alt_o = '0;
      alt_oe = '0;
      // Port 2: bits 1-4 timer 0 out, bits 5-7 interrupt only
      alt_sel[PIN_P2_BASE+7:PIN_P2_BASE+1] = port2_function_select_q[7:1];
      alt_o[PIN_P2_BASE+4:PIN_P2_BASE+1] = timer0_outputs;                // see R7
      alt_oe[PIN_P2_BASE+4:PIN_P2_BASE+1] = 4'hf;
      // Port 3: timer 1 and serial lines
      alt_sel[PIN_P3_BASE+7:PIN_P3_BASE] = port3_function_select_q;
      alt_o[PIN_P3_BASE] = timer1_output_a;                              // see R7
      alt_o[PIN_P3_BASE+1] = timer1_output_b;
      alt_oe[PIN_P3_BASE+1:PIN_P3_BASE] = 2'h3;
      alt_o[PIN_P3_BASE+3] = sio1_mode ? sio1_serial_out : uart0_transmit_out; // see R8
      alt_oe[PIN_P3_BASE+3] = 1'b1;
      alt_o[PIN_P3_BASE+4] = sio1_clk_o;                                 // see R9
      alt_oe[PIN_P3_BASE+4] = sio1_mode && sio1_clk_oe;
      alt_o[PIN_P3_BASE+6] = sio2_mode ? sio2_serial_out : uart2_transmit_out; // see R9
      alt_oe[PIN_P3_BASE+6] = 1'b1;
      alt_o[PIN_P3_BASE+7] = sio2_clk_o;
      alt_oe[PIN_P3_BASE+7] = sio2_mode && sio2_clk_oe;
      // Ports 4 and 5: multiplexed address/data
      alt_sel[PIN_P5_BASE+7:PIN_P4_BASE] = {16{ext_mem_en}};             // see R10
      alt_o[PIN_P5_BASE+7:PIN_P4_BASE] = bus_ad_o;
      alt_oe[PIN_P4_BASE+7:PIN_P4_BASE] = {8{bus_ad_oe}};
      alt_oe[PIN_P5_BASE+7:PIN_P5_BASE] = {8{bus_ad_oe || !mode_s_q[0]}};
      // Port 6: upper address, only the pins the space needs
      alt_sel[PIN_P6_BASE+3:PIN_P6_BASE] = {4{ext_mem_en}} & upper_addr_used; // see R11
      alt_o[PIN_P6_BASE+3:PIN_P6_BASE] = upper_address_bits;
      alt_oe[PIN_P6_BASE+3:PIN_P6_BASE] = 4'hf;
      // Port 9: strobes and wait
      alt_sel[PIN_WAIT:PIN_P9_BASE] = {5{ext_mem_en}} & port9_function_select_q[4:0];
      alt_sel[PIN_HIGH_WR] = alt_sel[PIN_HIGH_WR] && mode_s_q[0];        // see R13
      alt_o[PIN_READ_STROBE] = read_strobe;                              // see R12
      alt_o[PIN_LOW_WR] = low_byte_write_strobe;                         // see R13
      alt_o[PIN_HIGH_WR] = high_byte_write_strobe;
      alt_o[PIN_ADDR_LATCH] = address_latch_strobe;                      // see R14
      alt_oe[PIN_ADDR_LATCH:PIN_READ_STROBE] = 4'hf;
   end

   // ==========================================================
   // Pin cells
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         localparam int PORT = gi / 8;
         // Ports without a pull-up group point at index 0 and are masked by HAS_PU
         localparam int PU_IDX = (PORT == 9) ? 4 : (PORT >= 4 && PORT <= 6) ? PORT - 3 : 0;
         localparam bit HAS_PU = (PORT == 0) || (PORT == 4) || (PORT == 5) ||
                                 (PORT == 6) || (PORT == 9);
         logic sel;
         assign sel = reg_wr && (reg_port == 4'(PORT));
         pin_cell #(
            .EXISTS(PIN_EXISTS[gi]),
            .BIDIR(PIN_BIDIR[gi])                                        // see R3
         ) u_cell (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .wr_latch(sel && reg_kind == KIND_LATCH),
            .wr_dir(sel && reg_kind == KIND_DIR),
            .wdata(reg_wdata[gi % 8]),
            .pin_s(pin_s_q[gi]),
            .alt_sel(alt_sel[gi]),
            .alt_o(alt_o[gi]),
            .alt_oe(alt_oe[gi]),
            .pull_grp(HAS_PU && pullup_en[PU_IDX]),                      // see R2
            .pin_o(pin_o[gi]),
            .pin_oe(pin_oe[gi]),
            .pin_pu(pin_pu[gi]),
            .rd(port_rd[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Standby mode select and clock output
   logic standby_q, standby_d, clk_out_q, clk_out_d, run;
   always_comb begin
      standby_d = mode_s_q[1] && !mode_s_q[2];                           // see R16
      run = !idle_mode && !stop_mode;
      clk_out_d = run ? !clk_out_q : 1'b0;                               // see R17
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         standby_q <= 1'b0;
         clk_out_q <= 1'b0;
      end else begin
         standby_q <= standby_d;
         clk_out_q <= clk_out_d;
      end
   end
   assign standby_disabled = standby_q;
   assign system_clock_out = clk_out_q;

   // ==========================================================
   // Assertions
   property p_nmi_no_drive;
      @(posedge sys_clk) disable iff (!rst_n) !pin_oe[PIN_NMI];
   endproperty
   a_nmi_no_drive: assert property (p_nmi_no_drive) else $error("nmi pin driven"); // see R3
   property p_analog_no_drive;
      @(posedge sys_clk) disable iff (!rst_n) pin_oe[PIN_P7_BASE+15:PIN_P7_BASE] == 16'h0000;
   endproperty
   a_analog_no_drive: assert property (p_analog_no_drive) else $error("port 7/8 driven"); // see R4
   property p_clk_low;
      @(posedge sys_clk) disable iff (!rst_n) (idle_mode || stop_mode) |=> !system_clock_out;
   endproperty
   a_clk_low: assert property (p_clk_low) else $error("clock out not low"); // see R17
   property p_clk_toggle;
      @(posedge sys_clk) disable iff (!rst_n)
         run |=> (system_clock_out != $past(system_clock_out));
   endproperty
   a_clk_toggle: assert property (p_clk_toggle) else $error("clock out not toggling"); // see R17
   property p_pull_input;
      @(posedge sys_clk) disable iff (!rst_n) (pin_pu & pin_oe) == '0;
   endproperty
   a_pull_input: assert property (p_pull_input) else $error("pull-up on driven pin"); // see R2
   property p_no_high_wr_8bit;
      @(posedge sys_clk) disable iff (!rst_n)
         !mode_s_q[0] |=> pin_o[PIN_HIGH_WR] == $past(g_pin[PIN_HIGH_WR].u_cell.latch_q);
   endproperty
   a_no_high_wr_8bit: assert property (p_no_high_wr_8bit) // see R13
      else $error("high strobe in 8-bit");
   property p_bus_owns_ad;
      @(posedge sys_clk) disable iff (!rst_n)
         ext_mem_en |=> pin_o[PIN_P5_BASE+7:PIN_P4_BASE] == $past(bus_ad_o);
   endproperty
   a_bus_owns_ad: assert property (p_bus_owns_ad) else $error("bus data not on pins"); // see R10
   property p_alt_override;
      @(posedge sys_clk) disable iff (!rst_n)
         alt_sel[PIN_P2_BASE+1] |=> pin_o[PIN_P2_BASE+1] == $past(timer0_outputs[0]) &&
                                    pin_oe[PIN_P2_BASE+1];
   endproperty
   a_alt_override: assert property (p_alt_override) else $error("timer out not on pin"); // see R22
   property p_nmi_read;
      @(posedge sys_clk) disable iff (!rst_n)
         1'b1 |=> port_rd[PIN_NMI] == $past(pin_s_q[PIN_NMI]);
   endproperty
   a_nmi_read: assert property (p_nmi_read) else $error("port 2 bit 0 read wrong"); // see R19
   property p_strobe_pin;
      @(posedge sys_clk) disable iff (!rst_n)
         alt_sel[PIN_READ_STROBE] |=> pin_o[PIN_READ_STROBE] == $past(read_strobe);
   endproperty
   a_strobe_pin: assert property (p_strobe_pin) else $error("read strobe not on pin"); // see R12
   c_bus_active: cover property (@(posedge sys_clk) disable iff (!rst_n)
      ext_mem_en && mode_s_q[0]);
   c_clk_stop: cover property (@(posedge sys_clk) disable iff (!rst_n) run ##1 stop_mode);
   c_sio_clk_drive: cover property (@(posedge sys_clk) disable iff (!rst_n)
      pin_oe[PIN_P3_BASE+4]);
endmodule : port_pin_function_mux
`default_nettype wire

// file: dv/pin_side_model.sv
// Purpose: Far side of the shared pins: outside logic and pull-ups.
// Assumes: A pin the device drives shows the device value.
// Notes: A released pin with no pull-up and no outside driver toggles each cycle.
`timescale 1ns/100ps
`default_nettype none
module pin_side_model (
   // Clock
   input wire logic sys_clk,
   // Device side
   input wire logic [79:0] pin_o,
   input wire logic [79:0] pin_oe,
   input wire logic [79:0] pin_pu,
   // Outside drivers, wait pin among them
   input wire logic [79:0] ext_drv,
   input wire logic [79:0] ext_val,
   // Wire level
   output logic [79:0] pin_i
);
   logic float_q = 1'b0;
   always_ff @(posedge sys_clk) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int k = 0; k < 80; k++) begin
         if (pin_oe[k]) begin
            pin_i[k] = pin_o[k];
         end else if (ext_drv[k]) begin
            pin_i[k] = ext_val[k];
         end else if (pin_pu[k]) begin
            pin_i[k] = 1'b1;
         end else begin
            pin_i[k] = float_q;
         end
      end
   end
endmodule : pin_side_model
`default_nettype wire

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the port and pin-function mux.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes: Waits are fixed counts taken from the stated latencies.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import port_mux_pkg::*;
   logic sys_clk, rst_n, reg_wr;
   logic [3:0] reg_port;
   reg_kind_t reg_kind;
   logic [7:0] reg_wdata;
   logic [4:0] pullup_en;
   logic [79:0] pin_i, pin_o, pin_oe, pin_pu, port_rd, ext_drv, ext_val;
   logic nmi_req, adc_start_trig, timer1_output_a, timer1_output_b;
   logic [6:0] ext_irq_inputs;
   logic [3:0] capture_trig, timer0_outputs, upper_address_bits, upper_addr_used;
   logic [15:0] analog_channel_inputs, bus_ad_o, muxed_addr_data_bus;
   logic sio1_mode, sio2_mode, uart0_transmit_out, uart2_transmit_out, sio1_serial_out;
   logic sio2_serial_out, sio1_clk_o, sio1_clk_oe, sio2_clk_o, sio2_clk_oe;
   logic uart0_receive_in, uart0_baud_clock_in, uart2_receive_in, uart2_baud_clock_in;
   logic sio1_serial_in, sio1_shift_clock, sio2_serial_in, sio2_shift_clock;
   logic ext_mem_en, bus_ad_oe, read_strobe, low_byte_write_strobe, high_byte_write_strobe;
   logic address_latch_strobe, bus_wait_in, bus_width_select, standby_disable_select;
   logic test_mode_pin, idle_mode, stop_mode, bus_width_16, standby_disabled;
   logic system_clock_out, a, b;
   int n_mismatch, samples_checked;
   port_pin_function_mux i_port_pin_function_mux (.sys_clk, .rst_n, .reg_wr, .reg_port,
      .reg_kind, .reg_wdata, .pullup_en, .pin_i, .pin_o, .pin_oe, .pin_pu, .port_rd,
      .nmi_req, .ext_irq_inputs, .capture_trig, .adc_start_trig, .analog_channel_inputs,
      .timer0_outputs, .timer1_output_a, .timer1_output_b, .sio1_mode, .sio2_mode,
      .uart0_transmit_out, .uart2_transmit_out, .sio1_serial_out, .sio2_serial_out,
      .sio1_clk_o, .sio1_clk_oe, .sio2_clk_o, .sio2_clk_oe, .uart0_receive_in,
      .uart0_baud_clock_in, .uart2_receive_in, .uart2_baud_clock_in, .sio1_serial_in,
      .sio1_shift_clock, .sio2_serial_in, .sio2_shift_clock, .ext_mem_en, .bus_ad_o,
      .bus_ad_oe, .upper_address_bits, .upper_addr_used, .read_strobe,
      .low_byte_write_strobe, .high_byte_write_strobe, .address_latch_strobe,
      .muxed_addr_data_bus, .bus_wait_in, .bus_width_select, .standby_disable_select,
      .test_mode_pin, .idle_mode, .stop_mode, .bus_width_16, .standby_disabled,
      .system_clock_out);
   pin_side_model i_pin_side_model (.sys_clk, .pin_o, .pin_oe, .pin_pu, .ext_drv,
      .ext_val, .pin_i);
   // ===============
   // Tasks
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick
   task automatic wr_reg(input logic [3:0] p, input reg_kind_t k, input logic [7:0] d);
      reg_port = p;
      reg_kind = k;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
   endtask : wr_reg
   task automatic settle;
      reg_wr = 1'b0;
      tick(8);
   endtask : settle
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      #50000;
      n_mismatch++;
      end_of_test;
   end
   // ===============
   // Scenarios
   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      {rst_n, reg_wr, reg_port, reg_wdata, pullup_en, timer0_outputs, timer1_output_a} = '0;
      {timer1_output_b, sio1_mode, sio2_mode, uart0_transmit_out, uart2_transmit_out} = '0;
      {sio1_serial_out, sio2_serial_out, sio1_clk_o, sio1_clk_oe, sio2_clk_o, sio2_clk_oe} = '0;
      {ext_mem_en, bus_ad_o, bus_ad_oe, upper_address_bits, upper_addr_used, read_strobe} = '0;
      {low_byte_write_strobe, high_byte_write_strobe, address_latch_strobe} = '0;
      {bus_width_select, standby_disable_select, test_mode_pin, idle_mode, stop_mode} = '0;
      reg_kind = KIND_NONE;
      ext_drv = {3'h0, 1'b1, 4'h0, 16'hffff, 24'h0, 6'h3f, 9'h0, 1'b1, 12'h0, 4'hf};
      ext_val = {3'h0, 1'b1, 4'h0, 16'h3ca5, 24'h0, 6'h3f, 9'h0, 1'b1, 12'h0, 4'h9};
      repeat (2) @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
      tick(4);
      check("oe_reset", pin_oe[15:0], 16'h0000);
      check("rd_input", port_rd[3:0], 4'h9);
      wr_reg(4'h0, KIND_LATCH, 8'h06);
      wr_reg(4'h0, KIND_DIR, 8'h0c);
      wr_reg(4'h1, KIND_DIR, 8'h00);
      wr_reg(4'h2, KIND_DIR, 8'h00);
      wr_reg(4'h7, KIND_DIR, 8'h00);
      pullup_en = 5'h03;
      settle;
      check("oe_p0_p1", pin_oe[15:0], 16'h0703);
      check("rd_mixed", port_rd[3:0], 4'ha);
      check("pu_p0", pin_pu[3:0], 4'hc);
      check("pu_p4", pin_pu[39:32], 8'hff);
      check("oe_p2", pin_oe[23:16], 8'hfe);
      check("oe_p7_p8", pin_oe[71:56], 16'h0000);
      check("analog", analog_channel_inputs, 16'h3ca5);
      check("rd_analog", port_rd[71:56], 16'h3ca5);
      timer0_outputs = 4'h5;
      timer1_output_a = 1'b1;
      sio1_mode = 1'b1;
      sio1_serial_out = 1'b1;
      sio1_clk_oe = 1'b1;
      uart2_transmit_out = 1'b1;
      wr_reg(4'h2, KIND_LATCH, 8'hff);
      wr_reg(4'h2, KIND_FUNC, 8'h1e);
      wr_reg(4'h3, KIND_DIR, 8'h24);
      wr_reg(4'h3, KIND_FUNC, 8'hdb);
      settle;
      check("p2_alt", pin_o[23:17], 7'h75);
      check("oe_p3", pin_oe[31:24], 8'h5b);
      check("p3_alt", {pin_o[30], pin_o[28:27], pin_o[25:24]}, 5'h15);
      check("irq", {nmi_req, adc_start_trig, capture_trig, ext_irq_inputs},
         {1'b1, 1'b1, 4'h5, 7'h75});
      check("ser_in", {uart0_receive_in, sio1_serial_in, uart2_receive_in, sio2_serial_in,
         sio2_shift_clock, uart2_baud_clock_in, sio1_shift_clock, uart0_baud_clock_in},
         8'hfc);
      sio1_mode = 1'b0;
      sio1_clk_oe = 1'b0;
      settle;
      check("ser_flip", {pin_o[27], pin_oe[28], sio1_shift_clock, uart0_baud_clock_in},
         4'h3);
      ext_mem_en = 1'b1;
      bus_ad_o = 16'ha53c;
      bus_ad_oe = 1'b1;
      upper_address_bits = 4'h9;
      upper_addr_used = 4'h3;
      read_strobe = 1'b1;
      high_byte_write_strobe = 1'b1;
      address_latch_strobe = 1'b1;
      wr_reg(4'h9, KIND_DIR, 8'h00);
      wr_reg(4'h9, KIND_FUNC, 8'h1f);
      settle;
      check("ad_out", pin_o[47:32], 16'ha53c);
      check("ad_oe", pin_oe[47:32], 16'hffff);
      check("ad_in", muxed_addr_data_bus, 16'ha53c);
      check("upper", {pin_oe[51:48], pin_o[49:48]}, {4'h3, 2'b01});
      check("strobe8", pin_o[75:72], 4'h9);
      check("p9_ctl", {pin_oe[76:72], bus_wait_in, bus_width_16}, {5'h0f, 2'b10});
      bus_ad_oe = 1'b0;
      settle;
      check("ad_oe8", pin_oe[47:32], 16'hff00);
      bus_width_select = 1'b1;
      settle;
      check("ad_oe16", pin_oe[47:32], 16'h0000);
      check("strobe16", {pin_o[75:72], bus_width_16}, 5'h1b);
      standby_disable_select = 1'b1;
      settle;
      check("stby_on", standby_disabled, 1'b1);
      test_mode_pin = 1'b1;
      settle;
      check("stby_test", standby_disabled, 1'b0);
      for (int m = 0; m < 3; m++) begin
         idle_mode = (m == 2);
         stop_mode = (m == 1);
         tick(2);
         a = system_clock_out;
         tick(1);
         b = system_clock_out;
         check("clk_out", {a, b}, (m == 0) ? {a, ~a} : 2'b00);
      end
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      settle;
      check("oe_p2_p3", pin_oe[31:16], 16'h0000);
      check("oe_p9", pin_oe[79:72], 8'h00);
      end_of_test;
   end
endmodule : tb_top
`default_nettype wire
